// ===== shared/angle_readout_pkg.sv
// ----------------------------------------------------------------
// Constants and carriers shared by the angle readout logic.
// ----------------------------------------------------------------
package angle_readout_pkg;
	// Widths of the serial frame and of its fields.
	localparam int FRAME_W = 16;
	localparam int ANGLE_W = 13;
	localparam int AVG_W = 3;
	localparam int OCT_W = 8;
	localparam int GAP_W = 18;
	localparam logic [3:0] LAST_BIT = 4'hf;
	// Base refresh period and the mclk rate it is counted in.
	localparam int MCLK_HZ = 40000000;
	localparam int BASE_PERIOD_US = 25;
	localparam int BASE_CYCLES = BASE_PERIOD_US * (MCLK_HZ / 1000000);
	// Register addresses carried in the command word.
	localparam logic [6:0] ADDR_ANGLE = 7'h00;
	localparam logic [6:0] ADDR_CTRL = 7'h01;
	localparam logic [6:0] ADDR_STATUS = 7'h02;
	localparam int LOW_SPEED_BIT = 2;
	localparam logic [15:0] WORD_RESET = 16'h0000;

	typedef logic [FRAME_W-1:0] word_t;

	// Command frame: write flag, register address, write data.
	typedef struct packed {
		logic write;
		logic [6:0] addr;
		logic [7:0] data;
	} cmd_s;

	// Angle word as it leaves the die, flags above the angle.
	typedef struct packed {
		logic supply_low;
		logic logic_fault;
		logic weak_field;
		logic [ANGLE_W-1:0] angle;
	} angle_word_s;

	// Status word with every diagnostic flag.
	typedef struct packed {
		logic [11:0] zero;
		logic supply_loss;
		logic supply_low;
		logic weak_field;
		logic logic_fault;
	} status_s;

	// Supply gating states.
	typedef enum logic [1:0] {
		PWR_LOCKED = 2'b00,
		PWR_RUN = 2'b01
	} pwr_e;
endpackage

// ===== tb/spi_host_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Host controller on the serial link, mode 3, clock idles high.
// ----------------------------------------------------------------
module spi_host_model (
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	input wire logic miso,
	input wire logic miso_oe,
	output angle_readout_pkg::word_t rx_word,
	output logic rx_done
);
	logic last_q;
	wire logic line;

	// A line nobody drives shows the inverse of its last level.
	assign line = miso_oe ? miso : ~last_q;

	// Idle levels: deselected, clock high, no frame done.
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		mosi = 1'b0;
		last_q = 1'b0;
		rx_word = '0;
		rx_done = 1'b0;
	end

	// Clock edges with the die deselected let the link logic settle.
	task automatic idle(input int n);
		repeat (n) begin
			#6 sclk = 1'b0;
			#6 sclk = 1'b1;
		end
	endtask

	// One whole frame: command out while the previous answer comes in.
	task automatic xfer(input angle_readout_pkg::word_t tx, input int half);
		cs_n = 1'b0;
		#130;
		for (int i = 15; i >= 0; i--) begin
			sclk = 1'b0;
			mosi = tx[i];
			#(half);
			sclk = 1'b1;
			rx_word[i] = line;
			last_q = line;
			#(half);
		end
		#5 cs_n = 1'b1;
		rx_done = 1'b1;
		#1 rx_done = 1'b0;
		#150;
	endtask
endmodule

// ===== tb/test_angle_sensor_spi_readout.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Self-checking bench: host frames in, answers checked from a queue.
// ----------------------------------------------------------------
module test_angle_sensor_spi_readout;
	localparam int BASE = 20;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic supply_ok = 1'b0;
	logic supply_low = 1'b0;
	logic [12:0] raw_angle = 13'h0000;
	logic [12:0] reference_angle = 13'h0000;
	logic [2:0] averaging_exponent = 3'h0;
	logic nv_low_speed = 1'b0;
	logic logic_fault_flag = 1'b0;
	logic weak_field_flag = 1'b0;
	logic supply_loss_flag = 1'b0;
	wire logic sclk, cs_n, mosi, miso, miso_oe, rx_done;
	wire logic low_speed_mode, sample_req, link_ready;
	angle_readout_pkg::word_t rx_word;
	logic [16:0] exp_q[$];
	logic [16:0] nxt;
	logic [16:0] e;
	int miscompares = 0;
	int num_checks = 0;
	int n;
	wire logic [15:0] angle_exp = {supply_low, logic_fault_flag,
		weak_field_flag, raw_angle - reference_angle};
	wire logic [15:0] stat_exp = {12'h000, 1'b1, supply_low,
		weak_field_flag, logic_fault_flag};

	// Clock at 40 MHz.
	always #12.5 mclk = ~mclk;

	angle_sensor_spi_readout #(.BASE_CYCLES(BASE)) dut (.mclk(mclk),
		.sys_rst(sys_rst), .supply_ok(supply_ok), .supply_low(supply_low),
		.raw_angle(raw_angle), .reference_angle(reference_angle),
		.averaging_exponent(averaging_exponent), .nv_low_speed(nv_low_speed),
		.logic_fault_flag(logic_fault_flag),
		.weak_field_flag(weak_field_flag), .supply_loss_flag(supply_loss_flag),
		.spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
		.spi_miso_oe(miso_oe), .low_speed_mode(low_speed_mode),
		.sample_req(sample_req), .link_ready(link_ready));

	spi_host_model host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
		.miso(miso), .miso_oe(miso_oe), .rx_word(rx_word),
		.rx_done(rx_done));

	// ----------------------------------------------------------------
	// Shared tasks.
	// ----------------------------------------------------------------
	task automatic tick();
		@(posedge mclk);
		#2;
	endtask

	task automatic check(input string what, input logic [15:0] want,
		input logic [15:0] got);
		num_checks++;
		if (got !== want) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, want, got);
		end
	endtask

	task automatic summarize();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Notes what this command will answer in the next frame, then sends it.
	task automatic cmd(input logic [15:0] c, input bit care,
		input logic [15:0] r, input int half = 6);
		exp_q.push_back(nxt);
		nxt = {care, r};
		host.xfer(c, half);
	endtask

	// Bounded wait for sample_req (0) or link_ready (1), counting cycles.
	task automatic wait_for(input bit which, output int cnt);
		cnt = 1;
		while ((which ? link_ready : sample_req) !== 1'b1) begin
			tick();
			cnt++;
			if (cnt > 9000) begin
				check("timeout", 16'h0000, 16'h0001);
				summarize();
			end
		end
	endtask

	// Measures one full spacing between two sample pulses.
	task automatic period(input int want);
		int cnt;
		tick();
		wait_for(1'b0, cnt);
		tick();
		wait_for(1'b0, cnt);
		check("period", 16'(want), 16'(cnt));
	endtask

	// Each finished frame pops the oldest note and is compared with it when its care bit is set.
	always @(posedge rx_done) begin
		if (exp_q.size() == 0) begin
			check("queue", 16'h0001, 16'h0000);
		end else begin
			e = exp_q.pop_front();
			if (e[16]) begin
				check("frame", e[15:0], rx_word);
			end
		end
	end

	// ----------------------------------------------------------------
	// Main sequence.
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(58467));
		averaging_exponent = 3'($urandom % 4);
		nxt = 17'h00000;
		host.idle(4);
		repeat (5) tick();
		sys_rst = 1'b0;
		// Answers during lockout are not trusted and the write is dropped.
		cmd(16'h8104, 0, 16'h0000);
		tick();
		check("link_ready", 16'h0000, 16'(link_ready));
		supply_ok = 1'b1;
		wait_for(1'b1, n);
		check("mode", 16'(nv_low_speed), 16'(low_speed_mode));
		host.idle(4);
		#100;
		period(BASE);
		// Angle reads with fresh random inputs, low speed from pass two.
		for (int i = 0; i < 4; i++) begin
			if (i == 2) begin
				cmd(16'h8104, 0, 16'h0000);
			end
			tick();
			raw_angle = 13'($urandom);
			reference_angle = 13'($urandom);
			{supply_low, logic_fault_flag, weak_field_flag} = 3'($urandom);
			repeat (3 * (BASE << (low_speed_mode * averaging_exponent))) tick();
			cmd(16'h0000, 1, angle_exp);
		end
		check("mode", 16'h0001, 16'(low_speed_mode));
		period(BASE << averaging_exponent);
		cmd(16'h0100, 1, 16'h0004);
		cmd(16'h8100, 0, 16'h0000);
		period(BASE);
		// A supply-loss pulse is held until the status is read.
		tick();
		supply_loss_flag = 1'b1;
		tick();
		supply_loss_flag = 1'b0;
		cmd(16'h0200, 1, stat_exp);
		cmd(16'h0200, 1, stat_exp & 16'hfff7);
		cmd(16'h7f00, 1, 16'h0000);
		cmd(16'h80ff, 0, 16'h0000);
		cmd(16'h0000, 1, angle_exp);
		cmd(16'h7f00, 1, 16'h0000);
		// Second power-up reloads the mode from the stored bit.
		tick();
		sys_rst = 1'b1;
		nv_low_speed = 1'b1;
		host.idle(4);
		repeat (5) tick();
		sys_rst = 1'b0;
		check("reset mode", 16'h0000, 16'(low_speed_mode));
		nxt = 17'h00000;
		wait_for(1'b1, n);
		check("mode", 16'h0001, 16'(low_speed_mode));
		host.idle(4);
		#100;
		cmd(16'h0100, 1, 16'h0004);
		cmd(16'h0000, 0, 16'h0000);
		summarize();
	end
endmodule

// ===== verilog/angle_sensor_spi_readout.sv
`timescale 1ns/10ps
// Summary of operation
// - Commands are ignored until supply rises above release; lockout below it.
// - Supply-low flag travels inside the angle word.
// - Low-speed refresh period is 25 us times two to the exponent.
// - Averaging exponent comes from non-volatile configuration bits.
// - Mode bit selects low-speed or high-speed refresh.
// - Each die keeps its own independent speed mode.
// - Returned data is chosen by the address of the previous command, read or write.
// - Angle word is valid in either mode at any rotation speed.
// - Word goes out MSB first with one framing in all modes.
// - Angle is an unsigned 13-bit field at full resolution.
// - Sampling runs on its own cycle; reads poll the latest result.
// - Worst latency two sample cycles plus two frames.
// - Best latency one and a half frames.
// - Writing one to control bit 2 selects low-speed mode.
// - Power-up restores defaults and reloads mode from non-volatile bit.
// - Reported angle is raw angle minus reference angle.
// - Distinct flags for logic fault, weak field and supply loss.
module angle_sensor_spi_readout #(
	parameter int BASE_CYCLES = angle_readout_pkg::BASE_CYCLES
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic supply_ok,
	input wire logic supply_low,
	input wire logic [12:0] raw_angle,
	input wire logic [12:0] reference_angle,
	input wire logic [2:0] averaging_exponent,
	input wire logic nv_low_speed,
	input wire logic logic_fault_flag,
	input wire logic weak_field_flag,
	input wire logic supply_loss_flag,
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe,
	output logic low_speed_mode,
	output logic sample_req,
	output logic link_ready
);
	localparam int BASE_W = $clog2(BASE_CYCLES);
	localparam logic [BASE_W-1:0] BASE_LAST = BASE_W'(BASE_CYCLES - 1);

	logic sup_s1_q, sup_s2_q, low_s1_q, low_s2_q, cs_s1_q, cs_s2_q;
	logic tog_s1_q, tog_s2_q, tog_s3_q;
	angle_readout_pkg::pwr_e pwr_q;
	logic run_q, low_speed_q, sample_q, loss_q, oe_q;
	logic [BASE_W-1:0] base_cnt_q;
	logic [angle_readout_pkg::OCT_W-1:0] oct_cnt_q, oct_max;
	angle_readout_pkg::angle_word_s hold_q;
	angle_readout_pkg::word_t tx_word_q;
	angle_readout_pkg::status_s status;
	logic len_s1_q, len_s2_q, cmd_tog_q, miso_q;
	logic [3:0] rx_cnt_q;
	logic [14:0] rx_sh_q, tx_sh_q;
	angle_readout_pkg::cmd_s cmd_q;
	logic pwr_up, cmd_ok, ctrl_wr, status_rd;
	logic [angle_readout_pkg::ANGLE_W-1:0] angle_diff;

	// ----------------------------------------------------------------
	// Synchronisers into the mclk domain
	// ----------------------------------------------------------------
	// Two flops for supply_ok, supply_low and chip select, three for the frame-done toggle.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			sup_s1_q <= 1'b0;
			sup_s2_q <= 1'b0;
			low_s1_q <= 1'b0;
			low_s2_q <= 1'b0;
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
			tog_s1_q <= 1'b0;
			tog_s2_q <= 1'b0;
			tog_s3_q <= 1'b0;
		end else begin
			sup_s1_q <= supply_ok;
			sup_s2_q <= sup_s1_q;
			low_s1_q <= supply_low;
			low_s2_q <= low_s1_q;
			cs_s1_q <= spi_cs_n;
			cs_s2_q <= cs_s1_q;
			tog_s1_q <= cmd_tog_q;
			tog_s2_q <= tog_s1_q;
			tog_s3_q <= tog_s2_q;
		end
	end

	// A command is acted on only while the supply is good.
	assign pwr_up = (pwr_q == angle_readout_pkg::PWR_LOCKED) && sup_s2_q;
	assign cmd_ok = (tog_s2_q ^ tog_s3_q) && run_q;
	assign ctrl_wr = cmd_ok && cmd_q.write
		&& (cmd_q.addr == angle_readout_pkg::ADDR_CTRL);
	assign status_rd = cmd_ok && !cmd_q.write
		&& (cmd_q.addr == angle_readout_pkg::ADDR_STATUS);

	// ----------------------------------------------------------------
	// Supply gating
	// ----------------------------------------------------------------
	// Locked until the supply is good, back to locked when it drops.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pwr_q <= angle_readout_pkg::PWR_LOCKED;
			run_q <= 1'b0;
		end else begin
			case (pwr_q)
				angle_readout_pkg::PWR_LOCKED: begin
					if (sup_s2_q) begin
						pwr_q <= angle_readout_pkg::PWR_RUN;
						run_q <= 1'b1;
					end
				end
				angle_readout_pkg::PWR_RUN: begin
					if (!sup_s2_q) begin
						pwr_q <= angle_readout_pkg::PWR_LOCKED;
						run_q <= 1'b0;
					end
				end
				default: begin
					pwr_q <= angle_readout_pkg::PWR_LOCKED;
					run_q <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Speed mode
	// ----------------------------------------------------------------
	// Reloaded from the non-volatile bit at every power-up, then
	// steered by control writes; this die's own copy only.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			low_speed_q <= 1'b0;
		end else if (pwr_up) begin
			low_speed_q <= nv_low_speed;
		end else if (ctrl_wr) begin
			low_speed_q <= cmd_q.data[angle_readout_pkg::LOW_SPEED_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Refresh timer and sample hold
	// ----------------------------------------------------------------
	// Base ticks per sample: one in high speed, 2^exponent in low speed.
	assign oct_max = low_speed_q
		? ((8'h01 << averaging_exponent) - 8'h01) : 8'h00;

	// Free-running sample cycle, independent of serial activity.
	always_ff @(posedge mclk) begin
		if (sys_rst || !run_q) begin
			base_cnt_q <= '0;
			oct_cnt_q <= '0;
			sample_q <= 1'b0;
		end else if (base_cnt_q == BASE_LAST) begin
			base_cnt_q <= '0;
			sample_q <= (oct_cnt_q >= oct_max);
			oct_cnt_q <= (oct_cnt_q >= oct_max) ? '0 : oct_cnt_q + 8'h01;
		end else begin
			base_cnt_q <= base_cnt_q + BASE_W'(1);
			sample_q <= 1'b0;
		end
	end

	// Raw angle less the reference, wrapping modulo one full turn.
	assign angle_diff = raw_angle - reference_angle;
	// The whole word is taken in one edge, so reads never mix samples.
	always_ff @(posedge mclk) begin
		if (sys_rst || pwr_up) begin
			hold_q <= '0;
		end else if (run_q && (base_cnt_q == BASE_LAST)
			&& (oct_cnt_q >= oct_max)) begin
			hold_q.supply_low <= low_s2_q;
			hold_q.logic_fault <= logic_fault_flag;
			hold_q.weak_field <= weak_field_flag;
			hold_q.angle <= angle_diff;
		end
	end

	// Supply loss is sticky until the status word is read; set wins.
	always_ff @(posedge mclk) begin
		if (sys_rst || pwr_up) begin
			loss_q <= 1'b0;
		end else if (supply_loss_flag) begin
			loss_q <= 1'b1;
		end else if (status_rd) begin
			loss_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Response selection
	// ----------------------------------------------------------------
	// Status word gathered from all diagnostics.
	always_comb begin
		status = '0;
		status.supply_loss = loss_q;
		status.supply_low = low_s2_q;
		status.weak_field = weak_field_flag;
		status.logic_fault = logic_fault_flag;
	end

	// Word for the next frame, picked by the last command's address.
	always_ff @(posedge mclk) begin
		if (sys_rst || !run_q) begin
			tx_word_q <= angle_readout_pkg::WORD_RESET;
		end else if (cmd_ok) begin
			case (cmd_q.addr)
				angle_readout_pkg::ADDR_ANGLE: tx_word_q <= hold_q;
				angle_readout_pkg::ADDR_CTRL: begin
					tx_word_q <= angle_readout_pkg::WORD_RESET;
					tx_word_q[angle_readout_pkg::LOW_SPEED_BIT] <= low_speed_q;
				end
				angle_readout_pkg::ADDR_STATUS: tx_word_q <= status;
				default: tx_word_q <= angle_readout_pkg::WORD_RESET;
			endcase
		end
	end

	// Output enable follows the synchronised chip select.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			oe_q <= 1'b0;
		end else begin
			oe_q <= run_q && !cs_s2_q;
		end
	end

	// ----------------------------------------------------------------
	// Link domain on the serial clock
	// ----------------------------------------------------------------
	// Link is held idle until the synchronised run level is seen.
	always_ff @(posedge spi_sclk) begin
		len_s1_q <= run_q;
		len_s2_q <= len_s1_q;
	end

	// Shift in on rising edges; the sixteenth bit closes the command.
	always_ff @(posedge spi_sclk) begin
		if (!len_s2_q) begin
			rx_cnt_q <= '0;
			cmd_tog_q <= 1'b0;
		end else if (spi_cs_n) begin
			rx_cnt_q <= '0;
		end else begin
			rx_cnt_q <= rx_cnt_q + 4'h1;
			rx_sh_q <= {rx_sh_q[13:0], spi_mosi};
			if (rx_cnt_q == angle_readout_pkg::LAST_BIT) begin
				cmd_q <= {rx_sh_q, spi_mosi};
				cmd_tog_q <= ~cmd_tog_q;
			end
		end
	end

	// Shift out on falling edges, most significant bit first.
	always_ff @(negedge spi_sclk) begin
		if (!len_s2_q) begin
			{miso_q, tx_sh_q} <= angle_readout_pkg::WORD_RESET;
		end else if (rx_cnt_q == 4'h0) begin
			{miso_q, tx_sh_q} <= tx_word_q;
		end else begin
			{miso_q, tx_sh_q} <= {tx_sh_q, 1'b0};
		end
	end

	assign spi_miso = miso_q;
	assign spi_miso_oe = oe_q;
	assign low_speed_mode = low_speed_q;
	assign sample_req = sample_q;
	assign link_ready = run_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Helper: cycles since the last sample while the mode held still.
	localparam int GAP_W = angle_readout_pkg::GAP_W;
	logic [GAP_W-1:0] gap_q, gap_exp;
	logic seen_q;
	assign gap_exp = low_speed_q
		? (GAP_W'(BASE_CYCLES) << averaging_exponent) - 18'h00001
		: GAP_W'(BASE_CYCLES - 1);
	always_ff @(posedge mclk) begin
		if (sys_rst || !run_q || pwr_up || ctrl_wr) begin
			gap_q <= '0;
			seen_q <= 1'b0;
		end else if (sample_q) begin
			gap_q <= '0;
			seen_q <= 1'b1;
		end else begin
			gap_q <= gap_q + 18'h00001;
		end
	end

	period_len_a: assert property (@(posedge mclk) disable iff (sys_rst)
		sample_q && seen_q |-> gap_q == gap_exp)
		else $error("refresh period wrong");
	lock_ignore_a: assert property (@(posedge mclk) disable iff (sys_rst)
		!run_q ##1 !run_q |-> $stable(low_speed_q) && tx_word_q == 16'h0000)
		else $error("command acted on while locked");
	power_reload_a: assert property (@(posedge mclk) disable iff (sys_rst)
		$rose(run_q) |-> low_speed_q == $past(nv_low_speed) && hold_q == '0)
		else $error("power-up did not reload defaults");
	angle_calc_a: assert property (@(posedge mclk) disable iff (sys_rst)
		sample_q |-> hold_q.angle == $past(angle_diff))
		else $error("angle not raw minus reference");
	flag_carry_a: assert property (@(posedge mclk) disable iff (sys_rst)
		sample_q |-> hold_q.supply_low == $past(low_s2_q)
		&& hold_q.weak_field == $past(weak_field_flag))
		else $error("flags not carried in angle word");
	mode_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
		ctrl_wr && !pwr_up |=> low_speed_q == $past(cmd_q.data[2]))
		else $error("control write did not set mode");
	read_select_a: assert property (@(posedge mclk) disable iff (sys_rst)
		cmd_ok && cmd_q.addr == 7'h00 |=> tx_word_q == $past(hold_q))
		else $error("angle read did not select hold word");
	hold_atomic_a: assert property (@(posedge mclk) disable iff (sys_rst)
		$changed(hold_q) && run_q && !$rose(run_q) |-> sample_q)
		else $error("hold word changed outside a sample");
	loss_sticky_a: assert property (@(posedge mclk) disable iff (sys_rst)
		run_q && supply_loss_flag && !pwr_up |=> loss_q
		##1 (loss_q || $past(status_rd) || $past(pwr_up)))
		else $error("supply loss flag not held");
	bit_order_a: assert property (@(posedge spi_sclk) disable iff (!len_s2_q)
		!spi_cs_n |-> miso_q == tx_word_q[4'hf - rx_cnt_q])
		else $error("serial bit order wrong");

	low_sample_c: cover property (@(posedge mclk) disable iff (sys_rst)
		sample_q && seen_q && low_speed_q);
	ctrl_write_c: cover property (@(posedge mclk) disable iff (sys_rst)
		ctrl_wr ##1 low_speed_q);
	angle_read_c: cover property (@(posedge mclk) disable iff (sys_rst)
		cmd_ok && cmd_q.addr == 7'h00 && !cmd_q.write);
endmodule
